// file: inc/lpms_pkg.sv
// package of the low power mode sequencer: register map, field positions,
// reset values, divider ratios, mode encoding and carrier structs.
// assumes one 200 MHz clock and a word-aligned AHB-Lite register window.
package lpms_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] ADDR_SCR1   = 8'h00;
  localparam logic [7:0] ADDR_SCR2   = 8'h04;
  localparam logic [7:0] ADDR_TMR    = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;

  // first system control register fields
  localparam int SCR1_SOFTWARE_STANDBY_BIT   = 7;
  localparam int SCR1_STS_LO = 4;
  localparam int SCR1_LOW_SPEED_ON_BIT   = 3;
  localparam int SCR1_MA_LO  = 0;
  localparam logic [7:0] SCR1_RST = 8'h03;

  // second system control register fields, top three bits read as one
  localparam int SCR2_NESEL  = 4;
  localparam int SCR2_DTON   = 3;
  localparam int SCR2_MEDIUM_SPEED_ON_BIT   = 2;
  localparam int SCR2_SA_LO  = 0;
  localparam logic [7:0] SCR2_RST  = 8'he0;
  localparam logic [7:0] SCR2_RSVD = 8'he0;

  // watch timer mode register, only the clock-select bit matters here
  localparam int TMR_TCS = 3;
  localparam logic [7:0] TMR_RST = 8'h00;

  // medium speed divider is osc/16 for a zero field
  localparam logic [2:0] MED_DIV_LOG2 = 3'h4;
  // subactive divide ratios as log2 of the divisor
  localparam logic [2:0] SUB_DIV8_LOG2 = 3'h3;
  localparam logic [2:0] SUB_DIV4_LOG2 = 3'h2;
  localparam logic [2:0] SUB_DIV2_LOG2 = 3'h1;
  // settling field values with the top bit set all give the longest wait
  localparam logic [2:0] STS_SHIFT_MAX = 3'h4;
  localparam int SETTLE_CNT_W = 18;

  // gray codes along active -> standby -> settle -> active medium
  typedef enum logic [3:0] {
    LPMS_ACT_HI  = 4'h0,
    LPMS_STANDBY = 4'h1,
    LPMS_SETTLE  = 4'h3,
    LPMS_ACT_MED = 4'h2,
    LPMS_SLP_MED = 4'h6,
    LPMS_SLP_HI  = 4'h7,
    LPMS_WATCH   = 4'h5,
    LPMS_SUBACT  = 4'h4,
    LPMS_SUBSLP  = 4'hc,
    LPMS_RST_HLD = 4'hd
  } lpms_mode_t;

  // wake sources: watch timer, external lines 3..0, edge inputs 7..0
  typedef struct packed {
    logic       watch_timer;
    logic [3:0] irq;
    logic [7:0] edge_in;
  } lpms_wake_t;

  // clock and pin controls toward the clock generators and ports
  typedef struct packed {
    logic sys_clk_run;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic watch_timer_run;
    logic gpio_hiz;
    logic gpio_hold;
  } lpms_ctrl_t;

endpackage : lpms_pkg

// file: hdl/lpms_divider.sv
// power-of-two enable divider: emits one pulse per 2**ratio input ticks.
// assumes tick_in is a one-cycle enable on clk and ratio stays below 8.
`timescale 1ns/100ps
module lpms_divider (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       tick_in,
  input  wire logic [2:0] ratio_log2,
  output logic            tick_out
);

  logic [6:0] cnt;
  logic [6:0] mask;

  // low bits all ones marks the last tick of a period
  assign mask = 7'((8'h01 << ratio_log2) - 8'h01);

  // free running count, so a ratio change takes effect within one period
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cnt <= 7'h00;
    else if (tick_in)
      cnt <= cnt + 7'h01;
  end

  // registered pulse keeps the enable glitch free
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      tick_out <= 1'b0;
    else
      tick_out <= tick_in && ((cnt & mask) == mask);
  end

endmodule : lpms_divider

// file: hdl/lpms_sequencer.sv
// low power mode sequencer: picks the mode a sleep instruction enters,
// the wake path out of it, the settling wait and the clock enables.
// assumes an AHB-Lite master, same-clock interrupt requests and enables,
// and reset pin and watch clock arriving asynchronously on pins.
//
// What this block does
// - sleep medium clocks peripherals at divider rate
// - sleep enters standby when standby set, others clear
// - standby stops system clock, retains state
// - standby floats all general purpose pins
// - standby leaves only on line 0/1 or reset
// - standby wake restarts clock, settles, then handles
// - standby wake resumes high or medium speed
// - masked or disabled interrupt keeps standby
// - reset pin restarts clock, release starts reset
// - settling field selects 8192 to 131072 states
// - sleep with standby and timer select enters watch
// - watch keeps only watch timer, holds pins
// - watch leaves on watch timer, line 0, reset
// - watch wake target from low/medium speed bits
// - watch wake to active waits settling first
// - subactive sleep enters subsleep on given bits
// - subsleep keeps only watch timer, holds pins
// - subsleep leaves at once on enabled wakes
// - subactive entered from watch or subsleep wakes
// - subactive sleep picks watch or subsleep
// - subactive cpu runs at watch clock /2,/4,/8
// - subactive divider encoding, locked in subactive
`timescale 1ns/100ps
module lpms_sequencer #(
  parameter int SETTLE_BASE_STATES = 8192
) (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic               sleep_exec,
  input  wire logic               ccr_i_mask,
  input  wire lpms_pkg::lpms_wake_t wake_req,
  input  wire lpms_pkg::lpms_wake_t wake_en,
  input  wire logic               reset_pin_n,
  input  wire logic               watch_clk_pin,
  output lpms_pkg::lpms_ctrl_t    ctrl,
  output lpms_pkg::lpms_mode_t    mode_state,
  output logic                    exc_int_start,
  output logic                    exc_reset_start,
  output logic                    cpu_reset
);

  lpms_pkg::lpms_mode_t mode;
  lpms_pkg::lpms_mode_t next_mode;
  lpms_pkg::lpms_mode_t settle_to;
  lpms_pkg::lpms_wake_t wake_ok;
  logic [7:0]  scr1;
  logic [7:0]  scr2;
  logic [7:0]  tmr;
  logic [2:0]  rp_sync;
  logic        rp_filt;
  logic [2:0]  wc_sync;
  logic        wc_filt;
  logic        wc_tick;
  logic        rst_low;
  logic        regs_rst;
  logic        ap_valid;
  logic        ap_write;
  logic        ap_lane0;
  logic [7:0]  ap_addr;
  logic        software_standby_bit;
  logic        low_speed_on_bit;
  logic        medium_speed_on_bit;
  logic        tcs;
  logic [2:0]  sts;
  logic [2:0]  sts_shift;
  logic [2:0]  med_log2;
  logic [2:0]  sub_log2;
  logic        med_tick;
  logic        sub_tick;
  logic [lpms_pkg::SETTLE_CNT_W-1:0] settle_cnt;
  logic [lpms_pkg::SETTLE_CNT_W-1:0] settle_last;
  logic        settle_done;
  logic        next_exc;
  logic        in_active;

  // field views of the control registers
  assign software_standby_bit = scr1[lpms_pkg::SCR1_SOFTWARE_STANDBY_BIT];
  assign low_speed_on_bit = scr1[lpms_pkg::SCR1_LOW_SPEED_ON_BIT];
  assign sts  = scr1[lpms_pkg::SCR1_STS_LO +: 3];
  assign medium_speed_on_bit = scr2[lpms_pkg::SCR2_MEDIUM_SPEED_ON_BIT];
  assign tcs  = tmr[lpms_pkg::TMR_TCS];
  assign in_active = (mode == lpms_pkg::LPMS_ACT_HI) || (mode == lpms_pkg::LPMS_ACT_MED);

  // three-stage pin synchronisers; only stages two and three are compared
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rp_sync <= 3'h7;
      wc_sync <= 3'h0;
    end
    else
    begin
      rp_sync <= {rp_sync[1:0], reset_pin_n};
      wc_sync <= {wc_sync[1:0], watch_clk_pin};
    end
  end

  // a level counts once two stages agree, filtering single-cycle noise
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rp_filt <= 1'b1;
      wc_filt <= 1'b0;
    end
    else
    begin
      if (rp_sync[1] == rp_sync[2])
        rp_filt <= rp_sync[2];
      if (wc_sync[1] == wc_sync[2])
        wc_filt <= wc_sync[2];
    end
  end

  assign rst_low  = !rp_filt;
  assign wc_tick  = (wc_sync[1] == wc_sync[2]) && wc_sync[2] && !wc_filt;
  assign regs_rst = sys_rst || rst_low;

  // AHB-Lite address phase capture; zero wait states, always OKAY
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_lane0 <= 1'b0;
      ap_addr  <= 8'h00;
    end
    else if (hready)
    begin
      ap_valid <= hsel && htrans[1] && (haddr[31:8] == 24'h000000);
      ap_write <= hwrite;
      ap_lane0 <= (haddr[1:0] == 2'h0) && (hsize <= 3'h2);
      ap_addr  <= haddr[7:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // read data latched at the address phase; unmapped reads give zero
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      hrdata <= 32'h00000000;
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      unique case (haddr[7:0])
        lpms_pkg::ADDR_SCR1:   hrdata <= {24'h000000, scr1};
        lpms_pkg::ADDR_SCR2:   hrdata <= {24'h000000, scr2};
        lpms_pkg::ADDR_TMR:    hrdata <= {24'h000000, tmr};
        lpms_pkg::ADDR_STATUS: hrdata <= {28'h0000000, mode};
        default:               hrdata <= 32'h00000000;
      endcase
    end
  end

  // register writes in the data phase; reset pin low clears them too
  always_ff @(posedge clk)
  begin
    if (regs_rst)
    begin
      scr1 <= lpms_pkg::SCR1_RST;
      scr2 <= lpms_pkg::SCR2_RST;
      tmr  <= lpms_pkg::TMR_RST;
    end
    else if (ap_valid && ap_write && ap_lane0)
    begin
      if (ap_addr == lpms_pkg::ADDR_SCR1)
        scr1 <= hwdata[7:0];
      if (ap_addr == lpms_pkg::ADDR_TMR)
        tmr <= hwdata[7:0];
      if (ap_addr == lpms_pkg::ADDR_SCR2)
      begin
        scr2[7:2] <= hwdata[7:2] | lpms_pkg::SCR2_RSVD[7:2];
        if (mode != lpms_pkg::LPMS_SUBACT)
          scr2[1:0] <= hwdata[1:0];
      end
    end
  end

  assign med_log2 = lpms_pkg::MED_DIV_LOG2 + {1'b0, scr1[lpms_pkg::SCR1_MA_LO +: 2]};

  always_comb
  begin
    if (scr2[lpms_pkg::SCR2_SA_LO + 1])
      sub_log2 = lpms_pkg::SUB_DIV2_LOG2;
    else if (scr2[lpms_pkg::SCR2_SA_LO])
      sub_log2 = lpms_pkg::SUB_DIV4_LOG2;
    else
      sub_log2 = lpms_pkg::SUB_DIV8_LOG2;
  end

  lpms_divider u_med_div (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .tick_in    (1'b1),
    .ratio_log2 (med_log2),
    .tick_out   (med_tick)
  );

  lpms_divider u_sub_div (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .tick_in    (wc_tick),
    .ratio_log2 (sub_log2),
    .tick_out   (sub_tick)
  );

  // mask bit and enables qualify wakes
  assign wake_ok = ccr_i_mask ? '0 : (wake_req & wake_en);

  assign sts_shift   = sts[2] ? lpms_pkg::STS_SHIFT_MAX : sts;
  assign settle_last = lpms_pkg::SETTLE_CNT_W'((SETTLE_BASE_STATES << sts_shift) - 1);
  assign settle_done = (settle_cnt == settle_last);

  // mode decision; reset pin overrides every other event
  always_comb
  begin
    next_mode = mode;
    next_exc  = 1'b0;
    unique case (mode)
      lpms_pkg::LPMS_ACT_HI, lpms_pkg::LPMS_ACT_MED:
      begin
        if (sleep_exec)
        begin
          if (software_standby_bit && tcs)
            next_mode = lpms_pkg::LPMS_WATCH;
          else if (software_standby_bit && !low_speed_on_bit)
            next_mode = lpms_pkg::LPMS_STANDBY;
          else if (!software_standby_bit && !low_speed_on_bit)
            next_mode = medium_speed_on_bit ? lpms_pkg::LPMS_SLP_MED : lpms_pkg::LPMS_SLP_HI;
        end
      end
      lpms_pkg::LPMS_SUBACT:
      begin
        if (sleep_exec && software_standby_bit && tcs)
          next_mode = lpms_pkg::LPMS_WATCH;
        else if (sleep_exec && !software_standby_bit && low_speed_on_bit && tcs)
          next_mode = lpms_pkg::LPMS_SUBSLP;
      end
      lpms_pkg::LPMS_SLP_HI, lpms_pkg::LPMS_SLP_MED:
      begin
        if (wake_ok != '0)
        begin
          next_mode = (mode == lpms_pkg::LPMS_SLP_MED) ? lpms_pkg::LPMS_ACT_MED
                                                        : lpms_pkg::LPMS_ACT_HI;
          next_exc  = 1'b1;
        end
      end
      lpms_pkg::LPMS_STANDBY:
      begin
        // only lines 0 and 1 wake
        if (wake_ok.irq[1] || wake_ok.irq[0])
          next_mode = lpms_pkg::LPMS_SETTLE;
      end
      lpms_pkg::LPMS_WATCH:
      begin
        if (wake_ok.watch_timer || wake_ok.irq[0])
        begin
          if (low_speed_on_bit)
          begin
            next_mode = lpms_pkg::LPMS_SUBACT;
            next_exc  = 1'b1;
          end
          else
            next_mode = lpms_pkg::LPMS_SETTLE;
        end
      end
      lpms_pkg::LPMS_SUBSLP:
      begin
        if (wake_ok != '0)
        begin
          next_mode = lpms_pkg::LPMS_SUBACT;
          next_exc  = 1'b1;
        end
      end
      lpms_pkg::LPMS_SETTLE:
      begin
        if (settle_done)
        begin
          next_mode = settle_to;
          next_exc  = 1'b1;
        end
      end
      lpms_pkg::LPMS_RST_HLD:
      begin
        next_mode = lpms_pkg::LPMS_ACT_HI;
      end
      default:
      begin
        next_mode = lpms_pkg::LPMS_ACT_HI;
      end
    endcase
    if (rst_low)
    begin
      next_mode = lpms_pkg::LPMS_RST_HLD;
      next_exc  = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      mode <= lpms_pkg::LPMS_ACT_HI;
    else
      mode <= next_mode;
  end

  // watch wake target by speed bits
  // resume target held over the wait
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      settle_to <= lpms_pkg::LPMS_ACT_HI;
    else if (mode != lpms_pkg::LPMS_SETTLE)
      settle_to <= medium_speed_on_bit ? lpms_pkg::LPMS_ACT_MED : lpms_pkg::LPMS_ACT_HI;
  end

  // settling counter restarts on each entry to the wait
  always_ff @(posedge clk)
  begin
    if (sys_rst || mode != lpms_pkg::LPMS_SETTLE)
      settle_cnt <= '0;
    else if (!settle_done)
      settle_cnt <= settle_cnt + 1'b1;
  end

  // exception start pulses; reset handling starts on pin release
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      exc_int_start   <= 1'b0;
      exc_reset_start <= 1'b0;
    end
    else
    begin
      exc_int_start   <= next_exc;
      exc_reset_start <= (mode == lpms_pkg::LPMS_RST_HLD) && !rst_low;
    end
  end

  always_comb
  begin
    ctrl.sys_clk_run = (mode != lpms_pkg::LPMS_STANDBY) && (mode != lpms_pkg::LPMS_WATCH)
                       && (mode != lpms_pkg::LPMS_SUBACT) && (mode != lpms_pkg::LPMS_SUBSLP);
    ctrl.cpu_clk_en  = (mode == lpms_pkg::LPMS_ACT_HI)
                       || ((mode == lpms_pkg::LPMS_ACT_MED) && med_tick)
                       || ((mode == lpms_pkg::LPMS_SUBACT) && sub_tick);
    ctrl.periph_clk_en = (mode == lpms_pkg::LPMS_ACT_HI) || (mode == lpms_pkg::LPMS_SLP_HI)
                         || (((mode == lpms_pkg::LPMS_ACT_MED)
                              || (mode == lpms_pkg::LPMS_SLP_MED)) && med_tick)
                         || ((mode == lpms_pkg::LPMS_SUBACT) && sub_tick);
    ctrl.watch_timer_run = (mode != lpms_pkg::LPMS_STANDBY) && !rst_low;
    ctrl.gpio_hiz  = (mode == lpms_pkg::LPMS_STANDBY);
    ctrl.gpio_hold = (mode == lpms_pkg::LPMS_WATCH) || (mode == lpms_pkg::LPMS_SUBSLP);
  end

  assign mode_state = mode;
  assign cpu_reset  = (mode == lpms_pkg::LPMS_RST_HLD);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_standby_entry;
    in_active && sleep_exec && software_standby_bit && !low_speed_on_bit && !tcs && !rst_low
      |=> mode == lpms_pkg::LPMS_STANDBY;
  endproperty
  a_standby_entry: assert property (p_standby_entry)
    else $error("sleep did not enter standby");

  property p_standby_quiet;
    mode == lpms_pkg::LPMS_STANDBY
      |-> !ctrl.sys_clk_run && !ctrl.cpu_clk_en && !ctrl.periph_clk_en && ctrl.gpio_hiz;
  endproperty
  a_standby_quiet: assert property (p_standby_quiet)
    else $error("standby left clocks running or pins driven");

  property p_standby_masked;
    mode == lpms_pkg::LPMS_STANDBY && ccr_i_mask && !rst_low
      |=> mode == lpms_pkg::LPMS_STANDBY && !exc_int_start;
  endproperty
  a_standby_masked: assert property (p_standby_masked)
    else $error("masked interrupt cleared standby");

  property p_settle_hold;
    mode == lpms_pkg::LPMS_SETTLE && !settle_done && !rst_low
      |=> mode == lpms_pkg::LPMS_SETTLE && !exc_int_start;
  endproperty
  a_settle_hold: assert property (p_settle_hold)
    else $error("settling wait ended early");

  property p_settle_end;
    mode == lpms_pkg::LPMS_SETTLE && settle_done && !rst_low
      |=> in_active && exc_int_start;
  endproperty
  a_settle_end: assert property (p_settle_end)
    else $error("no handling after settling wait");

  property p_watch_to_sub;
    mode == lpms_pkg::LPMS_WATCH && low_speed_on_bit && wake_ok.watch_timer && !rst_low
      |=> mode == lpms_pkg::LPMS_SUBACT && exc_int_start;
  endproperty
  a_watch_to_sub: assert property (p_watch_to_sub)
    else $error("watch wake did not reach subactive");

  property p_subsleep_entry;
    mode == lpms_pkg::LPMS_SUBACT && sleep_exec && !software_standby_bit && low_speed_on_bit && tcs && !rst_low
      |=> mode == lpms_pkg::LPMS_SUBSLP
          ##1 (mode == lpms_pkg::LPMS_SUBSLP || exc_int_start || cpu_reset);
  endproperty
  a_subsleep_entry: assert property (p_subsleep_entry)
    else $error("subactive sleep missed subsleep");

  property p_sa_locked;
    mode == lpms_pkg::LPMS_SUBACT && ap_valid && ap_write && !rst_low
      |=> $stable(scr2[1:0]);
  endproperty
  a_sa_locked: assert property (p_sa_locked)
    else $error("subactive divider changed in subactive");

  property p_reset_release;
    mode == lpms_pkg::LPMS_RST_HLD && !rst_low
      |=> exc_reset_start && mode == lpms_pkg::LPMS_ACT_HI;
  endproperty
  a_reset_release: assert property (p_reset_release)
    else $error("reset release did not start reset handling");

  property p_reset_clock;
    rst_low |=> cpu_reset && ctrl.sys_clk_run;
  endproperty
  a_reset_clock: assert property (p_reset_clock)
    else $error("reset pin low without clock or cpu reset");

  c_standby_wake: cover property (mode == lpms_pkg::LPMS_SETTLE ##1 exc_int_start);
  c_watch_sub:    cover property (mode == lpms_pkg::LPMS_WATCH ##1 mode == lpms_pkg::LPMS_SUBACT);
  c_subslp_wake:  cover property (mode == lpms_pkg::LPMS_SUBSLP ##1 mode == lpms_pkg::LPMS_SUBACT);
  c_reset_exit:   cover property (exc_reset_start);

endmodule : lpms_sequencer

// file: testbench/lpms_partner.sv
// far side of the sequencer: watch crystal and the board reset pin.
// assumes the bench raises rst_req for a board-level reset request.
`timescale 1ns/100ps
module lpms_partner #(
  parameter int HOLD_CYC = 32
) (
  input  wire logic clk,
  input  wire logic rst_req,
  output logic      reset_pin_n,
  output logic      watch_clk_pin
);
  int cnt = HOLD_CYC;

  // watch crystal runs free, phase unrelated to clk
  initial
  begin
    watch_clk_pin = 1'b0;
    forever #37.3 watch_clk_pin = ~watch_clk_pin;
  end

  // pin held low
  // pin stays low a fixed time after the request, standing in for oscillator start-up
  initial reset_pin_n = 1'b1;
  always @(posedge clk)
  begin
    if (rst_req)
    begin
      reset_pin_n <= 1'b0;
      cnt         <= 0;
    end
    else if (cnt < HOLD_CYC)
      cnt <= cnt + 1;
    else
      reset_pin_n <= 1'b1;
  end
endmodule : lpms_partner

// file: testbench/test_low_power_mode_sequencer.sv
// self-checking bench of the low power mode sequencer.
// assumes one 200 MHz clock; registers reached over AHB-Lite.
`timescale 1ns/100ps
module test_low_power_mode_sequencer;
  logic                 clk, sys_rst, hsel, hwrite, sleep_exec, ccr_i_mask, rst_req;
  logic                 hreadyout, hresp, exc_int_start, exc_reset_start, cpu_reset;
  logic                 reset_pin_n, watch_clk_pin;
  logic [31:0]          haddr, hwdata, hrdata, r;
  logic [1:0]           htrans;
  logic [2:0]           hsize;
  lpms_pkg::lpms_wake_t wake_req, wake_en;
  lpms_pkg::lpms_ctrl_t ctrl;
  lpms_pkg::lpms_mode_t mode_state;
  int                   err_count, total_checks, cyc, n;

  // short settling base keeps the run brief
  lpms_sequencer #(.SETTLE_BASE_STATES(8)) i_dut (.clk(clk), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .sleep_exec(sleep_exec), .ccr_i_mask(ccr_i_mask),
    .wake_req(wake_req), .wake_en(wake_en), .reset_pin_n(reset_pin_n),
    .watch_clk_pin(watch_clk_pin), .ctrl(ctrl), .mode_state(mode_state),
    .exc_int_start(exc_int_start), .exc_reset_start(exc_reset_start),
    .cpu_reset(cpu_reset));

  lpms_partner i_far (.clk(clk), .rst_req(rst_req), .reset_pin_n(reset_pin_n),
    .watch_clk_pin(watch_clk_pin));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // hang guard, well above the thousand-odd cycles needed
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      err_count++;
      stop_test();
    end
  end

  task stop_test;
    if (err_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      err_count++;
    end
  endtask : chk

  task chm(input lpms_pkg::lpms_mode_t m);
    chk(32'(mode_state), 32'(m));
  endtask : chm

  task one(input logic b);
    chk(32'(b), 32'h1);
  endtask : one

  task do_reset;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
  endtask : do_reset

  // one single-word transfer; waits on hready, never on a fixed count
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus

  task rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rd

  task sleep(input lpms_pkg::lpms_mode_t m);
    @(posedge clk);
    sleep_exec <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
    #1;
    chm(m);
  endtask : sleep

  task wait_mode(input lpms_pkg::lpms_mode_t m);
    n = 0;
    while (mode_state !== m && n < 400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_mode

  // request held ten cycles must leave the mode alone
  task idle_wake(input logic [12:0] w, input lpms_pkg::lpms_mode_t m);
    @(posedge clk);
    wake_req <= w;
    repeat (10) @(posedge clk);
    wake_req <= '0;
    #1;
    chm(m);
  endtask : idle_wake

  task wake_go(input logic [12:0] w, input lpms_pkg::lpms_mode_t m);
    @(posedge clk);
    wake_req <= w;
    wait_mode(m);
  endtask : wake_go

  task wake_end;
    @(posedge clk);
    wake_req <= '0;
  endtask : wake_end

  task t_regs;
    do_reset();
    rd(8'h00, 32'h03);
    rd(8'h04, 32'he0);
    rd(8'h08, 32'h00);
    rd(8'h0c, 32'h00);
    rd(8'h10, 32'h00);
    bus(1'b1, 8'h04, 32'h1f);
    rd(8'h04, 32'hff);
  endtask : t_regs

  // standby entry, refused wakes, then a timed settle
  task t_standby(input logic [2:0] sts);
    do_reset();
    bus(1'b1, 8'h04, {29'h0, sts[0], 2'h0});
    bus(1'b1, 8'h00, {24'h0, 1'b1, sts, 4'h3});
    sleep(lpms_pkg::LPMS_STANDBY);
    one(ctrl.gpio_hiz);
    chk(32'(ctrl.sys_clk_run), 32'h0);
    idle_wake(13'h0400, lpms_pkg::LPMS_STANDBY);
    @(posedge clk);
    ccr_i_mask <= 1'b1;
    idle_wake(13'h0100, lpms_pkg::LPMS_STANDBY);
    @(posedge clk);
    ccr_i_mask <= 1'b0;
    wake_go(13'h0200, lpms_pkg::LPMS_SETTLE);
    wait_mode(sts[0] ? lpms_pkg::LPMS_ACT_MED : lpms_pkg::LPMS_ACT_HI);
    chk(32'(n), (32'h8 << (sts[2] ? 3'h4 : {1'b0, sts[1:0]})));
    one(exc_int_start);
    wake_end();
  endtask : t_standby

  // cycles from one cpu enable pulse to the next
  task en_gap;
    n = 0;
    while (!ctrl.cpu_clk_en && n < 400)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (!ctrl.cpu_clk_en && n < 400);
  endtask : en_gap

  // sleep modes: divided peripheral clock in medium, cpu halted, any wake exits
  task t_sleep;
    do_reset();
    bus(1'b1, 8'h04, 32'h04);
    bus(1'b1, 8'h00, 32'h00);
    sleep(lpms_pkg::LPMS_SLP_MED);
    n = 0;
    // a cpu enable in sleep counts a hundred, so it cannot hide
    repeat (64)
    begin
      @(posedge clk);
      #1;
      if (ctrl.periph_clk_en)
        n++;
      if (ctrl.cpu_clk_en)
        n += 100;
    end
    chk(32'(n), 32'h4);
    wake_go(13'h0001, lpms_pkg::LPMS_ACT_MED);
    chk(32'(n), 32'h1);
    one(exc_int_start);
    wake_end();
    bus(1'b1, 8'h04, 32'h00);
    sleep(lpms_pkg::LPMS_SLP_HI);
    chk(32'(ctrl.cpu_clk_en), 32'h0);
    wake_go(13'h0800, lpms_pkg::LPMS_ACT_HI);
    chk(32'(n), 32'h1);
    wake_end();
  endtask : t_sleep

  task t_sub;
    do_reset();
    bus(1'b1, 8'h08, 32'h08);
    bus(1'b1, 8'h00, 32'h88);
    sleep(lpms_pkg::LPMS_WATCH);
    one(ctrl.gpio_hold);
    @(posedge clk);
    wake_en <= 13'h0fff;
    idle_wake(13'h1000, lpms_pkg::LPMS_WATCH);
    @(posedge clk);
    wake_en <= 13'h1fff;
    idle_wake(13'h0200, lpms_pkg::LPMS_WATCH);
    wake_go(13'h1000, lpms_pkg::LPMS_SUBACT);
    chk(32'(n), 32'h1);
    one(exc_int_start);
    wake_end();
    // divide by 8 of the 74.6 ns watch period is about 119 cycles, sync jitter aside
    en_gap();
    one((n >= 118) && (n <= 121));
    bus(1'b1, 8'h04, 32'h03);
    rd(8'h04, 32'he0);
    bus(1'b1, 8'h00, 32'h08);
    sleep(lpms_pkg::LPMS_SUBSLP);
    wake_go(13'h0080, lpms_pkg::LPMS_SUBACT);
    chk(32'(n), 32'h1);
    one(exc_int_start);
    wake_end();
    bus(1'b1, 8'h00, 32'h80);
    sleep(lpms_pkg::LPMS_WATCH);
    wake_go(13'h0100, lpms_pkg::LPMS_SETTLE);
    wait_mode(lpms_pkg::LPMS_ACT_HI);
    chk(32'(n), 32'h8);
    wake_end();
  endtask : t_sub

  task t_pin;
    do_reset();
    bus(1'b1, 8'h00, 32'h83);
    sleep(lpms_pkg::LPMS_STANDBY);
    @(posedge clk);
    rst_req <= 1'b1;
    wait_mode(lpms_pkg::LPMS_RST_HLD);
    one(cpu_reset);
    @(posedge clk);
    rst_req <= 1'b0;
    wait_mode(lpms_pkg::LPMS_ACT_HI);
    one(exc_reset_start);
    rd(8'h00, 32'h03);
  endtask : t_pin

  // main sequence
  initial
  begin
    {sys_rst, hsel, hwrite, sleep_exec, ccr_i_mask, rst_req} = 6'h30;
    err_count    = 0;
    total_checks = 0;
    haddr    = 32'h0;
    hwdata   = 32'h0;
    htrans   = 2'h0;
    hsize    = 3'h2;
    wake_req = '0;
    wake_en  = 13'h1fff;
    t_regs();
    t_sleep();
    for (int i = 0; i < 6; i++)
      t_standby(i < 5 ? 3'(i) : 3'h7);
    t_sub();
    t_pin();
    stop_test();
  end
endmodule : test_low_power_mode_sequencer
